// >>> common/mcsd_pkg.sv
// Types for the memory channel select and dispatch block
`include "mcsd_regs.svh"
package mcsd_pkg;
  typedef enum logic [1:0] {
    MCSD_GLOBAL_RW,
    MCSD_CONST_RO,
    MCSD_TEXTURE_RO
  } mcsd_space_t;

  typedef struct packed {
    logic        write;
    mcsd_space_t space;
    logic [31:0] addr;
    logic [31:0] data;
  } mcsd_lane_t;

  typedef struct packed {
    logic                     valid;
    logic [`MCSD_NUM_CH-1:0]  sel;
    mcsd_lane_t               lane;
  } mcsd_chan_req_t;

  typedef struct packed {
    logic [`MCSD_SEQ_W-1:0] seq;
    logic [`MCSD_GRP_W-1:0] gx;
    logic [`MCSD_GRP_W-1:0] gy;
  } mcsd_group_t;
endpackage

// >>> common/mcsd_regs.svh
// Constants for the memory channel select and dispatch block
`ifndef MCSD_REGS_SVH
`define MCSD_REGS_SVH
`define MCSD_CH_LSB       8
`define MCSD_CH8_MSB      10
`define MCSD_CH4_MSB      9
`define MCSD_CH8_BITS     3
`define MCSD_CH4_BITS     2
`define MCSD_SPAN_BYTES   256
`define MCSD_WAVE_ITEMS   64
`define MCSD_QUARTER      16
`define MCSD_QUARTERS     4
`define MCSD_PROC_CYCLES  2
`define MCSD_LINE_BYTES   64
`define MCSD_NUM_CU       4
`define MCSD_NUM_CH       8
`define MCSD_GRP_W        16
`define MCSD_SEQ_W        32
`define MCSD_SLOT_W       4
`endif

// >>> hdl/mcsd_chan_map.sv
// Address to channel and bank decode
`timescale 1ns/1ps
`default_nettype none
`include "mcsd_regs.svh"
module mcsd_chan_map (
  // Mode
  input  wire logic        four_channel,
  // Address in
  input  wire logic [31:0] addr,
  // Decode out
  output logic [2:0]       channel,
  output logic [21:0]      bank_row
);
  import mcsd_pkg::*;

  // Channel field always starts at bit 8; bank sits directly above it
  always_comb begin
    if (four_channel) begin
      channel  = {1'b0, addr[`MCSD_CH4_MSB:`MCSD_CH_LSB]};
      bank_row = addr[31:`MCSD_CH4_MSB+1];
    end else begin
      channel  = addr[`MCSD_CH8_MSB:`MCSD_CH_LSB];
      bank_row = {1'b0, addr[31:`MCSD_CH8_MSB+1]};
    end
  end
endmodule
`default_nettype wire

// >>> hdl/mcsd_dispatch.sv
// Work-group dispatcher with a retire count that steps on any held unit's done
`timescale 1ns/1ps
`default_nettype none
`include "mcsd_regs.svh"
module mcsd_dispatch (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      reset_n,
  // Launch
  input  wire logic                      launch,
  input  wire logic [`MCSD_GRP_W-1:0]    groups_x,
  input  wire logic [`MCSD_GRP_W-1:0]    groups_y,
  // Compute unit side
  input  wire logic [`MCSD_NUM_CU-1:0]   cu_free,
  input  wire logic [`MCSD_NUM_CU-1:0]   cu_done,
  output logic [`MCSD_NUM_CU-1:0]        cu_assign,
  output mcsd_pkg::mcsd_group_t          group_out,
  // Status
  output logic [`MCSD_SEQ_W-1:0]         retire_seq,
  output logic [`MCSD_SEQ_W-1:0]         launch_sequence_number,
  output logic                           busy
);
  import mcsd_pkg::*;

  logic [`MCSD_GRP_W-1:0] gx, gy, nx, ny, next_gx, next_gy, next_nx, next_ny;
  logic [`MCSD_SEQ_W-1:0] seq, ret, next_seq, next_ret;
  logic                   run, next_run;
  logic [`MCSD_NUM_CU-1:0] next_assign;
  logic [`MCSD_NUM_CU-1:0] held, next_held;
  mcsd_group_t            next_group;
  logic                   last;
  integer                 i;

  always_comb begin
    next_gx = gx;
    next_gy = gy;
    next_nx = nx;
    next_ny = ny;
    next_seq = seq;
    next_ret = ret;
    next_run = run;
    next_assign = '0;
    next_held = held;
    next_group = group_out;
    last = (gx == nx - 1'b1) && (gy == ny - 1'b1);
    if (launch && !run && !busy) begin
      next_gx = '0;
      next_gy = '0;
      next_seq = '0;
      next_ret = '0;
      next_nx = groups_x;
      next_ny = groups_y;
      next_run = (groups_x != '0) && (groups_y != '0);
    end else if (run) begin
      for (i = 0; i < `MCSD_NUM_CU; i++) begin
        if (cu_free[i] && !held[i] && next_assign == '0) begin
          next_assign[i] = 1'b1;
        end
      end
      if (next_assign != '0) begin
        next_held = held | next_assign;
        next_group.seq = seq;
        next_group.gx = gx;
        next_group.gy = gy;
        next_seq = seq + 1'b1;
        if (last) begin
          next_run = 1'b0;
        end else if (gx == nx - 1'b1) begin
          next_gx = '0;
          next_gy = gy + 1'b1;
        end else begin
          next_gx = gx + 1'b1;
        end
      end
    end
    // Retire count steps by one when any held unit reports done, not only the oldest group's unit
    if (busy && ret != seq && (cu_done & held) != '0) begin
      next_ret = ret + 1'b1;
      for (i = 0; i < `MCSD_NUM_CU; i++) begin
        if (cu_done[i]) begin
          next_held[i] = next_held[i] & ~held[i];
        end
      end
    end
  end

  assign busy = run || (ret != seq);
  assign retire_seq = ret;
  assign launch_sequence_number = seq;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      gx <= '0;
      gy <= '0;
      nx <= '0;
      ny <= '0;
      seq <= '0;
      ret <= '0;
      run <= 1'b0;
      held <= '0;
      cu_assign <= '0;
      group_out <= '0;
    end else begin
      gx <= next_gx;
      gy <= next_gy;
      nx <= next_nx;
      ny <= next_ny;
      seq <= next_seq;
      ret <= next_ret;
      run <= next_run;
      held <= next_held;
      cu_assign <= next_assign;
      group_out <= next_group;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/mcsd_top.sv
// Memory request channel steering with conflict serialization and dispatch
`timescale 1ns/1ps
`default_nettype none
`include "mcsd_regs.svh"
module mcsd_top (
  // Clock and reset
  input  wire logic                                  core_clk,
  input  wire logic                                  reset_n,
  // Configuration
  input  wire logic                                  four_channel,
  input  wire logic                                  quick_access_route,
  // Wavefront request from one compute unit
  input  wire logic                                  wave_valid,
  input  wire mcsd_pkg::mcsd_lane_t [`MCSD_WAVE_ITEMS-1:0] wave_lanes,
  output logic                                       wave_ready,
  // Channel side
  input  wire logic [`MCSD_NUM_CH-1:0]               chan_ready,
  output mcsd_pkg::mcsd_lane_t [`MCSD_NUM_CH-1:0]    chan_req,
  output logic [`MCSD_NUM_CH-1:0]                    chan_valid,
  output logic [`MCSD_NUM_CH-1:0][5:0]               chan_line_off,
  // Dispatcher
  input  wire logic                                  launch,
  input  wire logic [`MCSD_GRP_W-1:0]                groups_x,
  input  wire logic [`MCSD_GRP_W-1:0]                groups_y,
  input  wire logic [`MCSD_NUM_CU-1:0]               cu_free,
  input  wire logic [`MCSD_NUM_CU-1:0]               cu_done,
  output logic [`MCSD_NUM_CU-1:0]                    cu_assign,
  output mcsd_pkg::mcsd_group_t                      group_out,
  output logic [`MCSD_SEQ_W-1:0]                     retire_seq,
  output logic [`MCSD_SEQ_W-1:0]                     launch_sequence_number,
  output logic                                       dispatch_busy
);
  import mcsd_pkg::*;

  typedef enum logic [1:0] {
    MCSD_IDLE,
    MCSD_PROC,
    MCSD_ISSUE
  } mcsd_state_t;

  // Lane is a read of read-only space: identical addresses may share a slot
  function automatic logic mcsd_ro(input mcsd_lane_t l);
    return !l.write && (l.space != MCSD_GLOBAL_RW);
  endfunction

  mcsd_state_t                          state, next_state;
  mcsd_lane_t [`MCSD_WAVE_ITEMS-1:0]    wave, next_wave;
  logic [1:0]                           quarter, next_quarter;
  logic                                 pcnt, next_pcnt;
  logic [`MCSD_QUARTER-1:0]             pend, next_pend;
  logic [`MCSD_QUARTER-1:0]             grant;
  logic [`MCSD_QUARTER-1:0][2:0]        lane_ch;
  mcsd_lane_t [`MCSD_NUM_CH-1:0]        next_req;
  logic [`MCSD_NUM_CH-1:0]              next_valid, used;
  logic [`MCSD_NUM_CH-1:0][5:0]         next_off;
  logic [`MCSD_NUM_CH-1:0][31:0]        used_addr;
  logic [`MCSD_NUM_CH-1:0]              used_ro;
  mcsd_lane_t                           cur;
  logic [5:0]                           idx;
  integer                               i;

  // Decode each lane of the current quarter
  // A bank lies inside one channel, so one slot per channel also spaces bank hits
  genvar g;
  generate
    for (g = 0; g < `MCSD_QUARTER; g++) begin : g_map
      mcsd_chan_map u_map (
        .four_channel (four_channel),
        .addr         (wave[{quarter, 4'h0} + 6'(g)].addr),
        .channel      (lane_ch[g]),
        .bank_row     ()
      );
    end
  endgenerate

  assign wave_ready = (state == MCSD_IDLE);

  // Grant in lane order: a lane may go only if no older pending lane of its
  // channel is still waiting, except a read-only broadcast of the granted address,
  // which keeps arrival order per channel for all other lanes
  always_comb begin
    next_state = state;
    next_wave = wave;
    next_quarter = quarter;
    next_pcnt = pcnt;
    next_pend = pend;
    grant = '0;
    next_req = chan_req;
    next_valid = chan_valid & ~chan_ready;
    next_off = chan_line_off;
    used = chan_valid & ~chan_ready;
    used_addr = '0;
    used_ro = '0;
    cur = '0;
    idx = '0;
    unique case (state)
      MCSD_IDLE: begin
        if (wave_valid) begin
          next_wave = wave_lanes;
          next_quarter = '0;
          next_pcnt = 1'b0;
          next_state = MCSD_PROC;
        end
      end
      MCSD_PROC: begin
        next_pcnt = 1'b1;
        if (pcnt) begin
          next_pend = '1;
          next_state = MCSD_ISSUE;
        end
      end
      MCSD_ISSUE: begin
        for (i = 0; i < `MCSD_QUARTER; i++) begin
          idx = {quarter, 4'h0} + 6'(i);
          cur = wave[idx];
          if (pend[i]) begin
            if (!used[lane_ch[i]]) begin
              if (!(four_channel && lane_ch[i][2])) begin
                grant[i] = 1'b1;
                used[lane_ch[i]] = 1'b1;
                used_addr[lane_ch[i]] = cur.addr;
                used_ro[lane_ch[i]] = mcsd_ro(cur);
                next_req[lane_ch[i]] = cur;
                next_valid[lane_ch[i]] = 1'b1;
                next_off[lane_ch[i]] = cur.addr[5:0];
              end
            end else if (used_ro[lane_ch[i]] && mcsd_ro(cur)
                         && used_addr[lane_ch[i]] == cur.addr
                         && next_valid[lane_ch[i]] && !(chan_valid[lane_ch[i]]
                         && !chan_ready[lane_ch[i]])) begin
              // Read-only broadcast rides on the slot already granted
              grant[i] = 1'b1;
            end
            // Same-address global reads fall through to a later cycle
            // regardless of quick_access_route, since both paths collide
            used[lane_ch[i]] = used[lane_ch[i]] | quick_access_route
                               | !quick_access_route;
          end
        end
        next_pend = pend & ~grant;
        if ((pend & ~grant) == '0) begin
          next_quarter = quarter + 2'h1;
          next_pcnt = 1'b0;
          next_state = (quarter == 2'(`MCSD_QUARTERS - 1)) ? MCSD_IDLE : MCSD_PROC;
        end
      end
      default: next_state = MCSD_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= MCSD_IDLE;
      wave <= '0;
      quarter <= '0;
      pcnt <= 1'b0;
      pend <= '0;
      chan_req <= '0;
      chan_valid <= '0;
      chan_line_off <= '0;
    end else begin
      state <= next_state;
      wave <= next_wave;
      quarter <= next_quarter;
      pcnt <= next_pcnt;
      pend <= next_pend;
      chan_req <= next_req;
      chan_valid <= next_valid;
      chan_line_off <= next_off;
    end
  end

  mcsd_dispatch u_dispatch (
    .core_clk               (core_clk),
    .reset_n                (reset_n),
    .launch                 (launch),
    .groups_x               (groups_x),
    .groups_y               (groups_y),
    .cu_free                (cu_free),
    .cu_done                (cu_done),
    .cu_assign              (cu_assign),
    .group_out              (group_out),
    .retire_seq             (retire_seq),
    .launch_sequence_number (launch_sequence_number),
    .busy                   (dispatch_busy)
  );
endmodule
`default_nettype wire

// >>> tb/mcsd_chan_model.sv
// Behavioural model of the channel controllers behind the crossbar
`timescale 1ns/1ps
`default_nettype none
`include "mcsd_regs.svh"
module mcsd_chan_model
  import mcsd_pkg::*;
(
  // Clock and reset
  input  wire logic                                    core_clk,
  input  wire logic                                    reset_n,
  // Bench control
  input  wire logic                                    slow,
  input  wire logic                                    clr,
  // Channel side
  input  wire logic [`MCSD_NUM_CH-1:0]                 chan_valid,
  input  wire mcsd_pkg::mcsd_lane_t [`MCSD_NUM_CH-1:0] chan_req,
  output var logic [`MCSD_NUM_CH-1:0]                  chan_ready,
  // Tallies
  output var int                                       cnt [`MCSD_NUM_CH],
  output var int                                       order_err
);
  int last [`MCSD_NUM_CH];
  int phase;
  // Ready ignores valid, so a stalled request must hold by itself
  always begin
    chan_ready = '0;
    forever begin
      @(posedge core_clk);
      for (int c = 0; c < `MCSD_NUM_CH; c++) begin
        if (!reset_n || clr) begin
          cnt[c] = 0;
          last[c] = -1;
        end else if (chan_valid[c] && chan_ready[c]) begin
          if (int'(chan_req[c].data) <= last[c]) order_err++;
          last[c] = int'(chan_req[c].data);
          cnt[c]++;
        end
      end
      if (!reset_n) order_err = 0;
      phase++;
      #1 chan_ready = slow ? {`MCSD_NUM_CH{phase % 3 == 0}} : '1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/mcsd_top_properties.sv
// Port-level checker for channel steering and dispatch
`timescale 1ns/1ps
`default_nettype none
`include "mcsd_regs.svh"
module mcsd_top_checker
  import mcsd_pkg::*;
(
  // Clock and reset
  input wire logic                                     core_clk,
  input wire logic                                     reset_n,
  // Wave side
  input wire logic                                     four_channel,
  input wire logic                                     wave_valid,
  input wire logic                                     wave_ready,
  // Channel side
  input wire logic [`MCSD_NUM_CH-1:0]                  chan_ready,
  input wire mcsd_pkg::mcsd_lane_t [`MCSD_NUM_CH-1:0]  chan_req,
  input wire logic [`MCSD_NUM_CH-1:0]                  chan_valid,
  input wire logic [`MCSD_NUM_CH-1:0][5:0]             chan_line_off,
  // Dispatcher
  input wire logic [`MCSD_NUM_CU-1:0]                  cu_free,
  input wire logic [`MCSD_NUM_CU-1:0]                  cu_assign,
  input wire logic [`MCSD_SEQ_W-1:0]                   retire_seq,
  input wire logic [`MCSD_SEQ_W-1:0]                   launch_sequence_number
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  for (genvar i = 0; i < `MCSD_NUM_CH; i++) begin : g_ch
    chan_map_a: assert property (
      chan_valid[i] |-> (four_channel ? chan_req[i].addr[9:8] == i : chan_req[i].addr[10:8] == i))
      else $error("request on wrong channel");
    line_off_a: assert property (
      chan_valid[i] |-> chan_line_off[i] == chan_req[i].addr[5:0])
      else $error("line offset mismatch");
    req_hold_a: assert property (
      chan_valid[i] && !chan_ready[i] |=> chan_valid[i] && $stable(chan_req[i]))
      else $error("stalled request changed");
  end
  // A quarter needs two processing cycles before any channel sees it
  proc_gap_a: assert property (
    wave_valid && wave_ready |=> (chan_valid == '0) [*2] ##[1:2] chan_valid != '0)
    else $error("quarter forwarded at wrong time");
  reset_zero_a: assert property (
    !$past(reset_n) |-> retire_seq == '0 && launch_sequence_number == '0 && cu_assign == '0)
    else $error("state not cleared by reset");
  assign_one_a: assert property ($onehot0(cu_assign))
    else $error("more than one unit assigned");
  assign_free_a: assert property ((cu_assign & ~$past(cu_free)) == '0)
    else $error("group given to unit without capacity");
  retire_step_a: assert property (
    retire_seq == $past(retire_seq) || retire_seq == $past(retire_seq) + 32'h1)
    else $error("retire count jumped");
endmodule
bind mcsd_top mcsd_top_checker u_mcsd_top_checker (
  .core_clk, .reset_n, .four_channel, .wave_valid, .wave_ready, .chan_ready, .chan_req,
  .chan_valid, .chan_line_off, .cu_free, .cu_assign, .retire_seq, .launch_sequence_number
);
`default_nettype wire

// >>> tb/mcsd_top_tb.sv
// Self-checking bench for channel steering and work-group dispatch
`timescale 1ns/1ps
`default_nettype none
`include "mcsd_regs.svh"
module mcsd_top_tb;
  import mcsd_pkg::*;
  typedef struct {
    logic        four;
    logic        wr;
    mcsd_space_t sp;
    logic        slow;
    logic [31:0] base;
    logic [31:0] stride;
    logic [7:0]  mask;
    logic        ser;
  } mcsd_row_t;
  logic                              core_clk, reset_n, four_channel, quick_access_route;
  logic                              wave_valid, wave_ready, launch, dispatch_busy, slow, clr;
  mcsd_lane_t [`MCSD_WAVE_ITEMS-1:0] wave_lanes;
  logic [`MCSD_NUM_CH-1:0]           chan_ready, chan_valid, got;
  mcsd_lane_t [`MCSD_NUM_CH-1:0]     chan_req;
  logic [`MCSD_NUM_CH-1:0][5:0]      chan_line_off;
  logic [`MCSD_GRP_W-1:0]            groups_x, groups_y;
  logic [`MCSD_NUM_CU-1:0]           cu_free, cu_done, cu_assign;
  mcsd_group_t                       group_out;
  logic [`MCSD_SEQ_W-1:0]            retire_seq, launch_sequence_number;
  int                                cnt [`MCSD_NUM_CH];
  int                                order_err, miscompares, checked, cycles, assigns, tot;
  int                                done_order [6] = '{0, 1, 2, 3, 0, 1};
  mcsd_row_t rows [10] = '{
    '{0, 1, MCSD_GLOBAL_RW,  0, 32'h0,   32'h4,    8'h01, 1},
    '{0, 1, MCSD_GLOBAL_RW,  1, 32'h0,   32'h20,   8'hff, 1},
    '{1, 1, MCSD_GLOBAL_RW,  0, 32'h0,   32'h10,   8'h0f, 1},
    '{1, 1, MCSD_GLOBAL_RW,  0, 32'h500, 32'h4,    8'h02, 1},
    '{0, 1, MCSD_GLOBAL_RW,  0, 32'h500, 32'h4,    8'h20, 1},
    '{0, 0, MCSD_GLOBAL_RW,  1, 32'h0,   32'h4000, 8'h01, 1},
    '{0, 0, MCSD_GLOBAL_RW,  0, 32'h300, 32'h0,    8'h08, 1},
    '{0, 0, MCSD_CONST_RO,   0, 32'h300, 32'h0,    8'h08, 0},
    '{0, 0, MCSD_TEXTURE_RO, 0, 32'h300, 32'h0,    8'h08, 0},
    '{0, 1, MCSD_GLOBAL_RW,  1, 32'h300, 32'h0,    8'h08, 1}
  };
  mcsd_top u_mcsd_top (
    .core_clk, .reset_n, .four_channel, .quick_access_route, .wave_valid, .wave_lanes,
    .wave_ready, .chan_ready, .chan_req, .chan_valid, .chan_line_off, .launch, .groups_x,
    .groups_y, .cu_free, .cu_done, .cu_assign, .group_out, .retire_seq,
    .launch_sequence_number, .dispatch_busy
  );
  mcsd_chan_model u_mcsd_chan_model (
    .core_clk, .reset_n, .slow, .clr, .chan_valid, .chan_req, .chan_ready, .cnt, .order_err
  );
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic print_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  // Every drive lands 1 ns after an edge so no input races the sampling edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic run_wave(input mcsd_row_t r);
    four_channel = r.four;
    slow = r.slow;
    quick_access_route = ~r.wr;
    clr = 1;
    for (int i = 0; i < `MCSD_WAVE_ITEMS; i++)
      wave_lanes[i] = '{r.wr, r.sp, r.base + 32'(i) * r.stride, 32'(i)};
    wave_valid = 1;
    for (int n = 0; n < 20 && wave_ready !== 1'b1; n++) tick(1);
    tick(1);
    {wave_valid, clr} = '0;
    for (int n = 0; n < 2000 && (wave_ready !== 1'b1 || chan_valid !== '0); n++) tick(1);
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (reset_n && |cu_assign) begin
      check(group_out.seq, assigns, "sequence");
      check({group_out.gx, group_out.gy}, {16'(assigns % 3), 16'(assigns / 3)}, "index");
      assigns++;
    end
    if (cycles == 30000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    {reset_n, four_channel, quick_access_route, wave_valid, launch, slow, clr} = '0;
    {wave_lanes, cu_free, cu_done, groups_x, groups_y} = '0;
    tick(2);
    reset_n = 1;
    foreach (rows[r]) begin
      run_wave(rows[r]);
      tot = 0;
      for (int c = 0; c < `MCSD_NUM_CH; c++) begin
        got[c] = cnt[c] != 0;
        tot += cnt[c];
      end
      check(got, rows[r].mask, "channel mask");
      check(rows[r].ser ? tot == 64 : tot < 64, 1, "accepted count");
      $display("wave test %0d done", r);
    end
    check(order_err, 0, "channel order");
    {groups_x, groups_y, cu_free} = {16'h3, 16'h2, 4'h7};
    launch = 1;
    tick(1);
    launch = 0;
    for (int i = 0; i < 50 && assigns < 3; i++) tick(1);
    tick(3);
    check(assigns, 3, "assigns with one unit full");
    cu_free = 4'hf;
    for (int i = 0; i < 50 && assigns < 4; i++) tick(1);
    check(assigns, 4, "first assigns");
    check(retire_seq, 0, "early retire");
    foreach (done_order[k]) begin
      cu_done = 4'h1 << done_order[k];
      tick(1);
      cu_done = '0;
      tick(4);
    end
    check(assigns, 6, "all assigns");
    check({retire_seq, launch_sequence_number}, {32'h6, 32'h6}, "retired");
    check(dispatch_busy, 0, "dispatch idle");
    $display("dispatch test done");
    wave_valid = 1;
    tick(2);
    wave_valid = 0;
    reset_n = 0;
    tick(2);
    reset_n = 1;
    check({wave_ready, chan_valid, cu_assign}, 13'h1000, "reset outputs");
    check(retire_seq | launch_sequence_number, 0, "reset counters");
    tick(2);
    check({wave_ready, chan_valid, cu_assign}, 13'h1000, "idle after reset");
    run_wave(rows[4]);
    check(cnt[5], 64, "wave after reset");
    $display("reset test done");
    print_verdict();
  end
endmodule
`default_nettype wire
